// [common/strap_map.vh]
// constants for the strap option latch
// ----------------------------------------------------------------------
// Notes on behaviour
// - sample all straps once at reset release
// - three address straps form address bits 2:0
// - address 0 broadcast unless strap or bit 9
// - address bits 4:3 are zero
// - mode 000 MII, 110 back-to-back, others reserved
// - isolate high enables, loads control bit 10
// - speed high is 100, sets select and advert
// - duplex high is half, loads control bit 8
// - autoneg strap high enables negotiation
// - test tree strap low enables test mode
// ----------------------------------------------------------------------
`ifndef STRAP_MAP_VH
`define STRAP_MAP_VH
`define MODE_MII 3'h0
`define MODE_B2B 3'h6
`define CTRL_ISO_BIT 10
`define CTRL_DUPLEX_BIT 8
`define CTRL_SPEED_BIT 13
`define CTRL_ANEG_BIT 12
`define CTRL_RST 16'h0000
`define CTRL2_BCAST_OFF_BIT 9
`define ADDR_HI_DEFAULT 2'h0
`define CAPTURE_DELAY 2'h2
`define WAIT_RST 2'h0
`define ADDR_RST 5'h00
`define MODE_RST 3'h0
`define SPEED_CAP_RST 1'h1
`define TREE_EN_RST 1'h0
`define BCAST_OFF_RST 1'h0
`endif

// [hw/strap_sync.v]
// two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module strap_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // levels
    input wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // first stage feeds only the second
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule
`default_nettype wire

// [hw/strap_option_latch.v]
// strap option latch: captures pin straps after reset release
`timescale 1ns/1ps
`default_nettype none
`include "strap_map.vh"
module strap_option_latch (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // strap pins
    input wire addr_strap_bit2,
    input wire addr_strap_bit1,
    input wire addr_strap_bit0,
    input wire [2:0] mode_strap,
    input wire isolate_strap,
    input wire speed_strap,
    input wire duplex_strap,
    input wire autoneg_enable_strap,
    input wire broadcast_disable_strap,
    input wire test_tree_strap_n,
    // software writes to control bits
    input wire ctrl_wr,
    input wire [15:0] ctrl_wdata,
    input wire ctrl2_wr,
    input wire bcast_off_wdata,
    // captured configuration
    output wire straps_valid,
    output wire [4:0] mgmt_addr,
    output wire [2:0] if_mode,
    output wire mode_reserved,
    output wire mode_b2b,
    output wire speed_cap_100,
    output wire broadcast_enabled,
    output wire nand_tree_en,
    output wire [15:0] ctrl_reg,
    output wire bcast_off_reg
);
    // ----------------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------------
    reg rst_meta_q;
    reg rst_sync_q;

    // asynchronous assert, synchronous release
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ----------------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------------
    wire [11:0] pins_raw;
    wire [11:0] pins_s;

    // pin order, msb first: tree_n, bcast off, aneg, duplex, speed, iso, mode, addr
    assign pins_raw = {test_tree_strap_n, broadcast_disable_strap, autoneg_enable_strap, duplex_strap,
                       speed_strap, isolate_strap, mode_strap, addr_strap_bit2, addr_strap_bit1,
                       addr_strap_bit0};

    // pins are board levels, not clocked with ref_clk
    strap_sync #(.WIDTH(12)) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_sync_q),
        .din(pins_raw),
        .dout(pins_s)
    );

    // ----------------------------------------------------------------------
    // named fields of the synchronised pins
    // ----------------------------------------------------------------------
    wire [2:0] addr_pin;
    wire [2:0] mode_pin;
    wire iso_pin;
    wire speed_pin;
    wire duplex_pin;
    wire aneg_pin;
    wire bcast_off_pin;
    wire tree_n_pin;

    // split the synchronised vector back into its straps
    assign addr_pin = pins_s[2:0];
    assign mode_pin = pins_s[5:3];
    assign iso_pin = pins_s[6];
    assign speed_pin = pins_s[7];
    assign duplex_pin = pins_s[8];
    assign aneg_pin = pins_s[9];
    assign bcast_off_pin = pins_s[10];
    assign tree_n_pin = pins_s[11];

    // ----------------------------------------------------------------------
    // one-time capture
    // ----------------------------------------------------------------------
    reg [1:0] wait_q;
    reg [1:0] wait_d;
    reg done_q;
    reg done_d;
    wire take;

    // take once synchronised pins reflect levels present at release
    assign take = !done_q && (wait_q == `CAPTURE_DELAY);

    // settle counter stops for good once the capture has happened
    always @* begin
        wait_d = wait_q;
        done_d = done_q;
        if (!done_q) begin
            if (take) begin
                done_d = 1'b1;
            end else begin
                wait_d = wait_q + 2'h1;
            end
        end
    end

    // settle counter and done flag
    always @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            wait_q <= `WAIT_RST;
            done_q <= 1'b0;
        end else begin
            wait_q <= wait_d;
            done_q <= done_d;
        end
    end

    // ----------------------------------------------------------------------
    // captured strap values
    // ----------------------------------------------------------------------
    reg [4:0] addr_q;
    reg [4:0] addr_d;
    reg [2:0] mode_q;
    reg [2:0] mode_d;
    reg b2b_q;
    reg b2b_d;
    reg reserved_q;
    reg reserved_d;
    reg speed_cap_q;
    reg speed_cap_d;
    reg tree_en_q;
    reg tree_en_d;

    // load once at capture, otherwise hold until the next reset
    always @* begin
        addr_d = addr_q;
        mode_d = mode_q;
        b2b_d = b2b_q;
        reserved_d = reserved_q;
        speed_cap_d = speed_cap_q;
        tree_en_d = tree_en_q;
        if (take) begin
            addr_d = {`ADDR_HI_DEFAULT, addr_pin};
            mode_d = mode_pin;
            b2b_d = (mode_pin == `MODE_B2B);
            reserved_d = (mode_pin != `MODE_MII) && (mode_pin != `MODE_B2B);
            speed_cap_d = speed_pin;
            tree_en_d = !tree_n_pin;
        end
    end

    // captured value registers, pin changes after capture are ignored
    always @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            addr_q <= `ADDR_RST;
            mode_q <= `MODE_RST;
            b2b_q <= 1'b0;
            reserved_q <= 1'b0;
            speed_cap_q <= `SPEED_CAP_RST;
            tree_en_q <= `TREE_EN_RST;
        end else begin
            addr_q <= addr_d;
            mode_q <= mode_d;
            b2b_q <= b2b_d;
            reserved_q <= reserved_d;
            speed_cap_q <= speed_cap_d;
            tree_en_q <= tree_en_d;
        end
    end

    // ----------------------------------------------------------------------
    // control bits: loaded by capture, then software owned
    // ----------------------------------------------------------------------
    reg [15:0] ctrl_q;
    reg [15:0] ctrl_d;
    reg bcast_off_q;
    reg bcast_off_d;
    reg bcast_en_q;

    // writes before capture are dropped so they cannot mask the straps
    always @* begin
        ctrl_d = ctrl_q;
        bcast_off_d = bcast_off_q;
        if (take) begin
            ctrl_d = `CTRL_RST;
            ctrl_d[`CTRL_ISO_BIT] = iso_pin;
            ctrl_d[`CTRL_SPEED_BIT] = speed_pin;
            ctrl_d[`CTRL_DUPLEX_BIT] = !duplex_pin;
            ctrl_d[`CTRL_ANEG_BIT] = aneg_pin;
            bcast_off_d = bcast_off_pin;
        end else if (done_q) begin
            if (ctrl_wr) begin
                ctrl_d = ctrl_wdata;
            end
            if (ctrl2_wr) begin
                bcast_off_d = bcast_off_wdata;
            end
        end
    end

    // control word, broadcast-off bit and its registered inverse
    always @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ctrl_q <= `CTRL_RST;
            bcast_off_q <= `BCAST_OFF_RST;
            bcast_en_q <= ~`BCAST_OFF_RST;
        end else begin
            ctrl_q <= ctrl_d;
            bcast_off_q <= bcast_off_d;
            bcast_en_q <= !bcast_off_d;
        end
    end

    // ----------------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ----------------------------------------------------------------------
    assign straps_valid = done_q;
    assign mgmt_addr = addr_q;
    assign if_mode = mode_q;
    assign mode_b2b = b2b_q;
    assign mode_reserved = reserved_q;
    assign speed_cap_100 = speed_cap_q;
    assign nand_tree_en = tree_en_q;
    assign ctrl_reg = ctrl_q;
    assign bcast_off_reg = bcast_off_q;
    // address 0 is broadcast unless disabled by strap-loaded or written bit
    assign broadcast_enabled = bcast_en_q;
endmodule
`default_nettype wire

// [testbench/strap_board.sv]
// board strap resistors feeding the strap pins
`timescale 1ns/1ps
`default_nettype none
module strap_board (
    // resistor pattern chosen by the bench
    input wire logic [11:0] lvl,
    // pin levels: addr[11:9] mode[8:6] iso speed duplex aneg bcast tree_n
    output logic [11:0] pins
);
    // resistors drive the pins steadily, no released state
    assign pins = lvl;
endmodule
`default_nettype wire

// [testbench/strap_option_latch_assertions.sv]
// checker for the strap option latch
`timescale 1ns/1ps
`default_nettype none
module strap_checks (
    input wire logic ref_clk, rst_n, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0, test_tree_strap_n,
    input wire logic ctrl_wr, straps_valid, mode_reserved, mode_b2b, speed_cap_100, broadcast_enabled,
    input wire logic nand_tree_en, bcast_off_reg, ctrl2_wr, bcast_off_wdata,
    input wire logic [15:0] ctrl_wdata, ctrl_reg,
    input wire logic [4:0] mgmt_addr,
    input wire logic [2:0] if_mode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence grab_s; $rose(straps_valid); endsequence
    valid_hold_a: assert property (straps_valid |=> straps_valid) else $error("valid dropped");
    grab_pins_a: assert property (grab_s |-> mgmt_addr[2:0] == {addr_strap_bit2, addr_strap_bit1,
        addr_strap_bit0} && nand_tree_en == !test_tree_strap_n) else $error("capture wrong");
    addr_high_a: assert property (straps_valid |-> mgmt_addr[4:3] == 2'h0) else $error("addr high");
    b2b_mode_a: assert property (mode_b2b == (if_mode == 3'h6)) else $error("b2b flag");
    reserved_mode_a: assert property (mode_reserved == (straps_valid && if_mode != 3'h0
        && if_mode != 3'h6)) else $error("reserved flag");
    bcast_flag_a: assert property (broadcast_enabled == !bcast_off_reg) else $error("bcast flag");
    straps_held_a: assert property (straps_valid && $past(straps_valid) |-> $stable({mgmt_addr,
        if_mode, speed_cap_100, nand_tree_en})) else $error("straps moved");
    ctrl_write_a: assert property (straps_valid && ctrl_wr |=> ctrl_reg == $past(ctrl_wdata))
        else $error("write lost");
    bcast_write_a: assert property (straps_valid && ctrl2_wr |=> bcast_off_reg == $past(bcast_off_wdata))
        else $error("bcast write lost");
endmodule
`default_nettype wire
bind strap_option_latch strap_checks u_chk (.*);

// [testbench/strap_option_latch_bench.sv]
// self-checking bench for the strap option latch
`timescale 1ns/1ps
`default_nettype none
module strap_option_latch_bench;
    logic ref_clk = 0, rst_n = 0, ctrl_wr = 0, ctrl2_wr = 0, bcast_off_wdata = 0;
    logic [15:0] ctrl_wdata = 16'h0000;
    logic [11:0] lvl = 12'h000, p;
    int n_errors = 0, samples_checked = 0, cyc = 0;
    wire straps_valid, mode_reserved, mode_b2b, speed_cap_100, broadcast_enabled, nand_tree_en, bcast_off_reg;
    wire [4:0] mgmt_addr;
    wire [2:0] if_mode;
    wire [15:0] ctrl_reg;
    strap_board board (.lvl(lvl), .pins(p));
    strap_option_latch DUT (.ref_clk(ref_clk), .rst_n(rst_n), .addr_strap_bit2(p[11]), .addr_strap_bit1(p[10]),
        .addr_strap_bit0(p[9]), .mode_strap(p[8:6]), .isolate_strap(p[5]), .speed_strap(p[4]),
        .duplex_strap(p[3]), .autoneg_enable_strap(p[2]), .broadcast_disable_strap(p[1]),
        .test_tree_strap_n(p[0]), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl2_wr(ctrl2_wr),
        .bcast_off_wdata(bcast_off_wdata), .straps_valid(straps_valid), .mgmt_addr(mgmt_addr),
        .if_mode(if_mode), .mode_reserved(mode_reserved), .mode_b2b(mode_b2b), .speed_cap_100(speed_cap_100),
        .broadcast_enabled(broadcast_enabled), .nand_tree_en(nand_tree_en), .ctrl_reg(ctrl_reg),
        .bcast_off_reg(bcast_off_reg));
    initial forever #50 ref_clk = ~ref_clk;
    // cycle ceiling against hangs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            conclude();
        end
    end
    task chk(input string s, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", s, e, g);
            n_errors++;
        end
    endtask
    // reset with a strap pattern, wait for capture, compare everything
    task boot(input logic [11:0] c);
        @(posedge ref_clk);
        lvl <= c;
        rst_n <= 1'b0;
        repeat (20) @(posedge ref_clk);
        // writes offered before capture must be ignored
        rst_n <= 1'b1;
        ctrl_wr <= 1'b1;
        ctrl2_wr <= 1'b1;
        ctrl_wdata <= 16'hFFFF;
        bcast_off_wdata <= !c[1];
        repeat (4) @(posedge ref_clk);
        ctrl_wr <= 1'b0;
        ctrl2_wr <= 1'b0;
        #1;
        chk("early", 16'h0000, 16'(straps_valid));
        @(posedge ref_clk);
        #1;
        chk("valid", 16'h0001, 16'(straps_valid));
        chk("b2b", 16'(c[8:6] == 3'h6), 16'(mode_b2b));
        chk("rsvd", 16'(c[8:6] != 3'h0 && c[8:6] != 3'h6), 16'(mode_reserved));
        chk("bcoff", 16'(c[1]), 16'(bcast_off_reg));
        chk("addr", {11'h000, 2'h0, c[11:9]}, 16'(mgmt_addr));
        chk("mode", 16'(c[8:6]), {13'h0000, if_mode});
        chk("ctrl", {2'h0, c[4], c[2], 1'b0, c[5], 1'b0, !c[3], 8'h00}, ctrl_reg);
        chk("cap", 16'(c[4]), 16'(speed_cap_100));
        chk("bcast", 16'(!c[1]), 16'(broadcast_enabled));
        chk("tree", 16'(!c[0]), 16'(nand_tree_en));
        @(posedge ref_clk);
        #1;
        chk("stay", 16'h0001, 16'(straps_valid));
    endtask
    // pins change after capture, software rewrites bits
    task late_change(input logic [11:0] c);
        boot(c);
        @(posedge ref_clk);
        lvl <= ~c;
        ctrl_wdata <= 16'hA5C3;
        ctrl_wr <= 1'b1;
        ctrl2_wr <= 1'b1;
        bcast_off_wdata <= 1'b1;
        @(posedge ref_clk);
        ctrl_wr <= 1'b0;
        ctrl2_wr <= 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        chk("held", {11'h000, 2'h0, c[11:9]}, 16'(mgmt_addr));
        chk("treeheld", 16'(!c[0]), 16'(nand_tree_en));
        chk("bcoffw", 16'h0001, 16'(bcast_off_reg));
        chk("ctrlw", 16'hA5C3, ctrl_reg);
        chk("bcw", 16'h0000, 16'(broadcast_enabled));
    endtask
    task conclude();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        boot(12'h000);
        boot(12'hFBF);
        boot(12'h123);
        late_change(12'hBC9);
        conclude();
    end
endmodule
`default_nettype wire
